// File: fx_seq_regs.svh
// Register offsets, field positions, reset values and timing counts of the sequencer.
`ifndef FX_SEQ_REGS_SVH
`define FX_SEQ_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_STORE_ADDR 8'h08
`define REG_STORE_DATA 8'h0c
`define REG_IN_SMP    8'h10
`define REG_OUT_SMP   8'h14
`define CTRL_RUN_BIT  0
`define CTRL_RESET    1'b1

// ----------------------------------------------------------------
// Word fields
// ----------------------------------------------------------------
`define NOP_WORD      32'h00030000
`define LFO_PITCH     31
`define LFO_SHAPE     30
`define LFO_M         18'h3ffff
`define LFO_QUARTER   18'h0ffff
`define LFO_H         24'h7fffff
`define LFO_STEP_SH   4
`define LFO_WORDS     4

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ  100000
`define XTAL_FREQ_KHZ 12288
`define XTAL_DIV_DEF  (`CLK_FREQ_KHZ / `XTAL_FREQ_KHZ)
`define FRAME_TICKS   256
`define PROG_WORDS    128
`define AUDIO_BITS    20
`define DATA_DEPTH    32768

`endif

// File: fx_seq_pkg.sv
// Types shared by the sequencer and its oscillators.
package fx_seq_pkg;
  // Sequencer states, Gray coded along idle, execute, gap.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_GAP  = 2'b11
  } seq_state_t;
  typedef logic signed [19:0] sample_t;
endpackage

// File: lfo_if.sv
// Connection between the sequencer and one low frequency oscillator.
`timescale 1ns/10ps
interface lfo_if;
  logic [31:0]        word;
  logic               load;
  logic               step;
  logic               cos_sel;
  logic signed [19:0] coef;
  logic [19:0]        xfade;
  logic signed [13:0] offset;
  modport ctl (output word, load, step, cos_sel, input coef, xfade, offset);
  modport osc (input word, load, step, cos_sel, output coef, xfade, offset);
endinterface

// File: lfo_osc.sv
// One low frequency oscillator: sinusoid, triangle or sawtooth with amplitude scaling.
`timescale 1ns/10ps
`include "fx_seq_regs.svh"
module lfo_osc
  import fx_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Sequencer side.
  lfo_if.osc        bus
);
  typedef struct packed {
    logic [31:0]        word;
    logic signed [23:0] val;
    logic               up;
    logic [17:0]        phase;
  } osc_t;
  osc_t s, n;
  logic [12:0]        f;
  logic [23:0]        stp;
  logic signed [24:0] t;
  logic [17:0]        p;
  logic [18:0]        ps;
  logic [22:0]        x;
  logic [46:0]        y;
  logic signed [23:0] sinv, wave, mag;
  logic signed [39:0] pa;
  logic [27:0]        d;

  // Next state: parameter load and one step per sample period.
  always_comb
  begin
    n = s;
    f = s.word[27:15];
    stp = {7'h00, f, 4'h0};
    t = '0;
    ps = {1'b0, s.phase} + {6'h00, f};
    if (bus.load)
      n.word = bus.word;
    if (bus.step)
    begin
      if (!s.word[`LFO_SHAPE])
        n.phase = (ps >= {1'b0, `LFO_M}) ? 18'(ps - {1'b0, `LFO_M}) : ps[17:0]; // R11
      else if (s.word[`LFO_PITCH])
      begin
        n.val = s.val + $signed(stp); // R08 R13
        n.up = 1'b1;
      end
      else if (s.up)
      begin
        t = 25'(s.val) + $signed({1'b0, stp});
        n.val = (t > $signed({1'b0, `LFO_H})) ? $signed(`LFO_H) : t[23:0]; // R12
        n.up = !(t > $signed({1'b0, `LFO_H}));
      end
      else
      begin
        t = 25'(s.val) - $signed({1'b0, stp});
        n.val = (t < -$signed({1'b0, `LFO_H})) ? -$signed(`LFO_H) : t[23:0]; // R12
        n.up = (t < -$signed({1'b0, `LFO_H}));
      end
    end
  end

  // Waveform: parabolic sine of the phase, or the linear value.
  always_comb
  begin
    p = bus.cos_sel ? 18'(({1'b0, s.phase} + {1'b0, `LFO_QUARTER}) % {1'b0, `LFO_M})
                    : s.phase;
    x = {p[16:0], 6'h00};
    y = {24'h0, x} * {23'h0, (24'h800000 - {1'b0, x})};
    sinv = (y[46:21] > 26'(`LFO_H)) ? $signed(`LFO_H) : $signed(y[44:21]);
    if (p[17])
      sinv = -sinv;
    wave = s.word[`LFO_SHAPE] ? s.val : sinv; // R09
    pa = 40'(wave) * $signed({25'h0, s.word[14:0]}); // R11
    mag = s.val[23] ? -s.val : s.val;
    d = {4'h0, 24'(`LFO_H - mag)};
    case (s.word[29:28]) // R10
      2'b11:   d = d << 4;
      2'b10:   d = d << 3;
      2'b01:   d = d << 1;
      default: d = d;
    endcase
    if (d > {4'h0, `LFO_H})
      d = {4'h0, `LFO_H};
  end

  assign bus.coef   = pa[38:19];
  assign bus.offset = pa[39:26]; // R14
  assign bus.xfade  = d[23:4];

  // State register.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= n;
  end
endmodule

// File: fx_seq.sv
// Effects program sequencer with oscillators, multiply-accumulate, delay memory and audio port.
//
// Operation
// R01: Bit clock is crystal/4; 20 bits each frame.
// R02: Samples are 20-bit two's complement fractions.
// R03: Step locations 0..127 in order every period.
// R04: Swap samples in the gap before location 0.
// R05: External mode turns two select pins serial.
// R06: Writable store executes exactly like built-in program.
// R07: Locations 0..3 oscillator words, rest instructions.
// R08: Bit 31 with triangle gives double-rate sawtooth.
// R09: Bit 30 picks triangle, else sinusoid.
// R10: Bits 29:28 pick crossfade length fraction.
// R11: Sine phase advances F/262143; amplitude scales.
// R12: Triangle steps between limits, reversing at 0x7FFFFF.
// R13: Sawtooth keeps direction and wraps over.
// R14: Chorus offsets address by amplitude/8 samples.
// R15: 0x00030000 is a no-op during oscillator loads.
// R16: Delay memory holds 32768 samples.
// R17: Word clock is crystal/256.
// R18: Source select high is built-in, low external.
// R19: Reset holds the counter at location 0.
// R20: Four independent oscillators, stepped once per period.
`timescale 1ns/10ps
`include "fx_seq_regs.svh"
module fx_seq
  import fx_seq_pkg::*;
#(
  parameter int XTAL_DIV   = `XTAL_DIV_DEF,
  parameter int DATA_DEPTH = `DATA_DEPTH
)
(
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Program selection pins.
  input  wire logic        int_ext_in,
  input  wire logic [3:0]  prog_sel_in,
  // Serial audio.
  input  wire logic        serial_audio_in,
  output logic             serial_audio_out,
  output logic             serial_bit_clock_out,
  output logic             sample_frame_clock_out
);
  localparam int AW = $clog2(DATA_DEPTH);
  localparam int DW = $clog2(XTAL_DIV);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t                        st;
    logic [DW-1:0]                     div;
    logic [7:0]                        tick;
    logic [6:0]                        pc;
    logic                              run;
    logic [6:0]                        waddr;
    logic [`PROG_WORDS-1:0][31:0]      store;
    logic [AW-1:0]                     base;
    logic [DATA_DEPTH-1:0][19:0]       dmem;
    sample_t                           acc;
    sample_t                           breg;
    sample_t                           creg;
    sample_t                           in_s;
    sample_t                           out_s;
    sample_t                           rx_s;
    logic [19:0]                       rx_sh;
    logic [19:0]                       tx_sh;
    logic                              sout;
    logic                              bclk;
    logic                              wclk;
    logic [1:0]                        ser;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
  } seq_t;

  seq_t               s, n;
  logic [1:0]         rst_sync_q;
  logic               rst_n;
  logic               xt;
  logic [31:0]        wd;
  logic [1:0]         lsel;
  logic [14:0]        addr;
  logic [AW-1:0]      ea;
  logic signed [13:0] off;
  sample_t            rd;
  sample_t            coef;
  sample_t            addend;
  logic signed [39:0] prod;
  logic signed [21:0] sum;
  logic [19:0]        mag20;
  logic [3:0]         ld;
  logic               stp;
  logic [7:0]         nt;
  logic               acc_wr;

  sample_t            lfo_coef [`LFO_WORDS];
  logic [19:0]        lfo_xf   [`LFO_WORDS];
  logic signed [13:0] lfo_off  [`LFO_WORDS];

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two-stage release of the asynchronous reset.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  lfo_if lfo [`LFO_WORDS] ();

  // Four oscillators, each with its own parameter word.
  for (genvar i = 0; i < `LFO_WORDS; i++)
  begin : g_lfo
    assign lfo[i].word    = wd;
    assign lfo[i].load    = ld[i];
    assign lfo[i].step    = stp; // R20
    assign lfo[i].cos_sel = wd[23];
    assign lfo_coef[i]    = lfo[i].coef;
    assign lfo_xf[i]      = lfo[i].xfade;
    assign lfo_off[i]     = lfo[i].offset;
    lfo_osc i_lfo_osc (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n),
      .bus      (lfo[i].osc)
    );
  end

  // ----------------------------------------------------------------
  // Program source
  // ----------------------------------------------------------------
  // Built-in program: one slow triangle per oscillator, then no-ops.
  function automatic logic [31:0] rom_word(input logic [3:0] prog, input logic [6:0] a);
    logic [31:0] w;
    w = `NOP_WORD;
    if (a < 7'(`LFO_WORDS))
      w = {4'b0100, 9'h000, prog, 15'h1000};
    return w;
  endfunction

  // Word at the current location from either store, same path after.
  always_comb
  begin
    wd = int_ext_in ? rom_word(prog_sel_in, s.pc) : s.store[s.pc]; // R06 R18
  end

  // ----------------------------------------------------------------
  // Sequencer, datapath, audio port and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    ld = '0;
    stp = 1'b0;
    acc_wr = 1'b0;
    xt = (s.div == DW'(XTAL_DIV - 1));
    n.div = xt ? '0 : DW'(s.div + 1'b1);
    nt = 8'(s.tick + 1'b1);

    // Instruction fields.
    lsel = wd[25:24];
    addr = wd[14:0];
    off = (wd[21] && wd[30]) ? lfo_off[lsel] : 14'sh0000; // R14
    ea = AW'(addr) + s.base + AW'(off);
    rd = (addr == 15'h0000) ? s.in_s : s.dmem[ea];
    mag20 = {1'b0, wd[30:24], 12'h000};
    if (wd[21])
      coef = wd[30] ? lfo_coef[lsel] : $signed(lfo_xf[lsel]);
    else
      coef = wd[31] ? -$signed(mag20) : $signed(mag20);
    prod = 40'(rd) * 40'(coef);
    case (wd[17:16])
      2'b11:   addend = s.acc;
      2'b10:   addend = s.creg;
      2'b01:   addend = s.breg;
      default: addend = '0;
    endcase
    sum = 22'(prod >>> 19) + 22'(addend);

    // Sequencing on each crystal tick.
    if (xt)
    begin
      case (s.st)
        SEQ_IDLE:
        begin
          n.tick = '0;
          n.pc = '0;
          n.wclk = 1'b1;
          n.bclk = 1'b0;
          if (s.run)
            n.st = SEQ_EXEC;
        end
        SEQ_EXEC:
        begin
          n.tick = nt;
          if (s.pc < 7'(`LFO_WORDS))
            ld[s.pc[1:0]] = 1'b1; // R07 R15
          else
            acc_wr = 1'b1; // R07
          if (s.pc == 7'(`PROG_WORDS - 1))
            n.st = SEQ_GAP;
          else
            n.pc = 7'(s.pc + 1'b1); // R03
        end
        SEQ_GAP:
        begin
          n.tick = nt;
          if (s.tick == 8'(`FRAME_TICKS - 1))
          begin
            n.in_s = s.rx_s; // R04
            n.tx_sh = {s.out_s[18:0], 1'b0}; // R04
            n.sout = s.out_s[19];
            n.base = AW'(s.base - 1'b1);
            stp = 1'b1; // R20
            n.pc = '0; // R03
            n.st = s.run ? SEQ_EXEC : SEQ_IDLE;
          end
        end
        default:
          n.st = SEQ_IDLE;
      endcase

      // Audio clocks and shifting follow the frame tick.
      if (s.st != SEQ_IDLE)
      begin
        n.bclk = nt[1]; // R01
        n.wclk = !nt[7]; // R17
        if (nt[1:0] == 2'b00 && nt != 8'h00)
        begin
          n.sout = s.tx_sh[19]; // R01
          n.tx_sh = {s.tx_sh[18:0], 1'b0};
        end
        if (nt[1:0] == 2'b10 && nt[7:2] < 6'(`AUDIO_BITS))
        begin
          n.rx_sh = {s.rx_sh[18:0], serial_audio_in}; // R01
          if (nt[7:2] == 6'(`AUDIO_BITS - 1))
            n.rx_s = {s.rx_sh[18:0], serial_audio_in}; // R02
        end
      end
    end

    // Multiply-accumulate with saturation to the 20-bit range.
    if (acc_wr)
    begin
      if (sum > 22'sh07ffff)
        n.acc = 20'sh7ffff; // R02
      else if (sum < -22'sh080000)
        n.acc = 20'sh80000;
      else
        n.acc = sum[19:0];
      if (wd[20])
        n.breg = s.acc;
      if (wd[19])
        n.creg = s.acc;
      if (wd[22] && addr == 15'h0000)
        n.out_s = s.acc;
      else if (wd[22])
        n.dmem[ea] = s.acc; // R16
    end

    // Serial programming lines replace two select pins in external mode.
    n.ser = int_ext_in ? 2'b00 : prog_sel_in[1:0]; // R05

    // APB: answer in the first access cycle; the error flag stands with ready only.
    n.pready = psel_in && !penable_in;
    n.pslverr = 1'b0;
    if (psel_in && !penable_in)
    begin
      case (paddr_in)
        `REG_CTRL:     n.prdata = {31'h0, s.run};
        `REG_STATUS:   n.prdata = {16'h0, s.ser, int_ext_in, prog_sel_in,
                                   s.st, s.pc};
        `REG_STORE_ADDR: n.prdata = {25'h0, s.waddr};
        `REG_STORE_DATA: n.prdata = s.store[s.waddr];
        `REG_IN_SMP:   n.prdata = {{12{s.in_s[19]}}, s.in_s};
        `REG_OUT_SMP:  n.prdata = {{12{s.out_s[19]}}, s.out_s};
        default:
        begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (psel_in && penable_in && s.pready && pwrite_in)
    begin
      case (paddr_in)
        `REG_CTRL:     n.run = pwdata_in[`CTRL_RUN_BIT];
        `REG_STORE_ADDR: n.waddr = pwdata_in[6:0];
        `REG_STORE_DATA:
        begin
          n.store[s.waddr] = pwdata_in;
          n.waddr = 7'(s.waddr + 1'b1);
        end
        default:       n.run = s.run;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset holds the counter at location 0; sequencing restarts after.
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0; // R19
      s.run <= `CTRL_RESET;
      s.wclk <= 1'b1;
    end
    else
      s <= n;
  end

  // Outputs straight from the state register.
  assign prdata_out             = s.prdata;
  assign pready_out             = s.pready;
  assign pslverr_out            = s.pslverr;
  assign serial_audio_out       = s.sout;
  assign serial_bit_clock_out   = s.bclk;
  assign sample_frame_clock_out = s.wclk;
endmodule

// File: fx_seq_assertions.sv
// Checker for the sequencer's bus handshake and serial audio timing.
`timescale 1ns/10ps
module fx_seq_assertions
#(
  parameter int XTAL_DIV = 8
)
(
  // Clock and reset.
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  // APB slave.
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Program pins and serial audio.
  input wire logic        int_ext_in,
  input wire logic [3:0]  prog_sel_in,
  input wire logic        serial_audio_in,
  input wire logic        serial_audio_out,
  input wire logic        serial_bit_clock_out,
  input wire logic        sample_frame_clock_out
);
  // ----------------------------------------------------------------
  // Serial clock tracking
  // ----------------------------------------------------------------
  logic        bclk_q;
  logic        fclk_q;
  logic        bseen_q;
  logic        fseen_q;
  logic [15:0] bcnt_q;
  logic [15:0] fcnt_q;
  logic [4:0]  idx_q;
  logic        bchg;
  logic        fchg;
  logic        bfall;
  logic [4:0]  idx_d;

  // The bit slot restarts at the frame start and saturates at slot 31, well past the 20-bit word.
  assign bchg  = serial_bit_clock_out != bclk_q;
  assign fchg  = sample_frame_clock_out != fclk_q;
  assign bfall = bchg && !serial_bit_clock_out;
  assign idx_d = !bfall ? idx_q : (fchg && sample_frame_clock_out) ? 5'h00 :
                 (idx_q == 5'h1f) ? idx_q : idx_q + 5'h01;

  // Counts clocks since each serial clock last changed.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bclk_q  <= 1'b0;
      fclk_q  <= 1'b1;
      bseen_q <= 1'b0;
      fseen_q <= 1'b0;
      bcnt_q  <= 16'h0000;
      fcnt_q  <= 16'h0000;
      idx_q   <= 5'h1f;
    end
    else
    begin
      bclk_q  <= serial_bit_clock_out;
      fclk_q  <= sample_frame_clock_out;
      bseen_q <= bseen_q | bchg;
      fseen_q <= fseen_q | fchg;
      bcnt_q  <= bchg ? 16'h0000 : bcnt_q + 16'h0001;
      fcnt_q  <= fchg ? 16'h0000 : fcnt_q + 16'h0001;
      idx_q   <= idx_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence apb_setup;
    psel_in && !penable_in && !pready_out;
  endsequence
  sequence frame_start;
    $rose(sample_frame_clock_out);
  endsequence
  sequence bit_fall;
    $fell(serial_bit_clock_out);
  endsequence

  a_ready_after_setup: assert property (apb_setup |=> pready_out)
    else $error("Ready missing after setup.");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("Ready held too long.");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("Ready outside an access.");
  a_error_reads_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("Error answer malformed.");
  a_frame_on_fall: assert property (frame_start |-> bit_fall)
    else $error("Frame start off the bit clock fall.");
  a_out_on_fall: assert property ($changed(serial_audio_out) |-> bit_fall)
    else $error("Output bit moved off the fall.");
  a_tail_bits_zero: assert property (idx_d >= 5'd20 |-> !serial_audio_out)
    else $error("Output not zero after the word.");
  a_bit_clock_half: assert property (bseen_q && bchg |-> bcnt_q == 16'(2 * XTAL_DIV - 1))
    else $error("Bit clock half period wrong.");
  a_frame_clock_half: assert property (fseen_q && fchg |-> fcnt_q == 16'(128 * XTAL_DIV - 1))
    else $error("Frame clock half period wrong.");
endmodule

// File: audio_codec_model.sv
// Behavioural serial codec: feeds the serial input and captures the serial output.
`timescale 1ns/10ps
module audio_codec_model
(
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Serial audio from the device.
  input  wire logic        bit_clock_in,
  input  wire logic        frame_clock_in,
  input  wire logic        dac_data_in,
  // Sample words on the bench side, and the serial data line into the device.
  input  wire logic [19:0] adc_word_in,
  output logic             adc_data_out,
  output logic      [19:0] dac_word_out
);
  logic        bclk_q;
  logic        fclk_q;
  logic [4:0]  idx_q;
  logic [4:0]  idx_d;
  logic [19:0] shift_q;

  // Bit slot of the frame, restarted where the frame clock rises.
  assign idx_d = (frame_clock_in && !fclk_q) ? 5'h00 :
                 (idx_q == 5'h1f) ? idx_q : idx_q + 5'h01;

  // Shift out on the falling bit clock and capture on the rising one, MSB first.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bclk_q       <= 1'b0;
      fclk_q       <= 1'b1;
      idx_q        <= 5'h1f;
      shift_q      <= 20'h00000;
      adc_data_out <= 1'b0;
      dac_word_out <= 20'h00000;
    end
    else
    begin
      bclk_q <= bit_clock_in;
      fclk_q <= frame_clock_in;
      if (bclk_q && !bit_clock_in)
      begin
        idx_q        <= idx_d;
        // Past the word the line toggles so that no stale bit can pass.
        adc_data_out <= (idx_d < 5'd20) ? adc_word_in[5'd19 - idx_d] : !adc_data_out;
      end
      if (!bclk_q && bit_clock_in && idx_q < 5'd20)
      begin
        shift_q <= {shift_q[18:0], dac_data_in};
        if (idx_q == 5'd19)
          dac_word_out <= {shift_q[18:0], dac_data_in};
      end
    end
  end
endmodule

// File: tb_fx_seq.sv
// Self-checking bench for the effects sequencer with a serial codec model.
`timescale 1ns/10ps
`include "fx_seq_regs.svh"
module tb_fx_seq;
  localparam int XD = 8;
  logic        mclk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        int_ext;
  logic [3:0]  prog_sel;
  logic        sdin;
  logic        sdout;
  logic        bclk;
  logic        fclk;
  logic [19:0] adc_word;
  logic [19:0] dac_word;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          num_checks;
  int          ticks [4] = '{0, 64, 127, 255};
  logic [19:0] vals [2] = '{20'h80001, 20'h7fffe};
  // Store program: half the input, add half again, then write the result out.
  logic [31:0] prog [3] = '{32'h40000000, 32'h40030000, 32'h00430000};

  fx_seq #(.XTAL_DIV(XD), .DATA_DEPTH(64)) i_fx_seq (
    .mclk_in(mclk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .int_ext_in(int_ext),
    .prog_sel_in(prog_sel), .serial_audio_in(sdin), .serial_audio_out(sdout),
    .serial_bit_clock_out(bclk), .sample_frame_clock_out(fclk));

  audio_codec_model i_audio_codec_model (
    .mclk_in(mclk), .rst_n_in(arst_n), .bit_clock_in(bclk), .frame_clock_in(fclk),
    .dac_data_in(sdout), .adc_word_in(adc_word), .adc_data_out(sdin),
    .dac_word_out(dac_word));

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the answer is taken at the rising edge that samples ready high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (pready !== 1'b1);
    chk("bus wait", 32'(t), 32'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic summarize;
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    arst_n = 1'b0;
    int_ext = 1'b1;
    prog_sel = 4'h5;
    adc_word = 20'h00000;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("location after reset", rd & 32'h7f, 32'h0);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("control reset", rd, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", {rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk("unmapped write", 32'(err), 32'h1);
    // Sample the sequencer state at chosen ticks of a frame.
    foreach (ticks[i])
    begin
      @(posedge fclk);
      repeat (ticks[i] * XD + 1) @(posedge mclk);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk("state", rd & 32'h180, (ticks[i] < 128) ? 32'h080 : 32'h180);
      if (ticks[i] < 128)
        chk("location", rd & 32'h7f, 32'(ticks[i]));
    end
    // Fill the whole writable store with no-ops, then place the copy program at 4..6.
    apb(1'b1, `REG_STORE_ADDR, 32'h0);
    for (int i = 0; i < 128; i++)
      apb(1'b1, `REG_STORE_DATA, `NOP_WORD | 32'(i & 3));
    apb(1'b0, `REG_STORE_ADDR, 32'h0);
    chk("store address wrap", rd & 32'h7f, 32'h0);
    apb(1'b1, `REG_STORE_ADDR, 32'h4);
    foreach (prog[i])
      apb(1'b1, `REG_STORE_DATA, prog[i]);
    for (int i = 3; i < 8; i++)
    begin
      apb(1'b1, `REG_STORE_ADDR, 32'(i));
      apb(1'b0, `REG_STORE_DATA, 32'h0);
      chk("store word", rd, (i > 3 && i < 7) ? prog[i - 4] : (`NOP_WORD | 32'(i & 3)));
    end
    int_ext <= 1'b0;
    prog_sel <= 4'h2;
    repeat (4) @(posedge mclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("pin status", rd & 32'hfe00, 32'h8400);
    // Loop extreme samples through the store program; bus writes to the output are ignored.
    foreach (vals[i])
    begin
      adc_word <= vals[i];
      apb(1'b1, `REG_OUT_SMP, {{12{~vals[i][19]}}, ~vals[i]});
      repeat (3) @(posedge fclk);
      repeat (90 * XD) @(posedge mclk);
      apb(1'b0, `REG_IN_SMP, 32'h0);
      chk("input sample", rd, {{12{vals[i][19]}}, vals[i]});
      chk("output sample", 32'(dac_word), 32'(vals[i] & 20'hffffe));
    end
    summarize();
  end
endmodule

bind fx_seq fx_seq_assertions #(.XTAL_DIV(XTAL_DIV)) i_fx_seq_assertions (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .int_ext_in(int_ext_in), .prog_sel_in(prog_sel_in),
  .serial_audio_in(serial_audio_in), .serial_audio_out(serial_audio_out),
  .serial_bit_clock_out(serial_bit_clock_out),
  .sample_frame_clock_out(sample_frame_clock_out));
